// *** fscr_pkg.sv ***
// Constants for the flash safety configuration register bank.
// Assumes a frame decoder delivers address/data write strobes on the same clock.
// Behaviour
// - Duration code 0..7 gives 156.25..1250 ms timeout.
// - Supply below threshold flags low battery, disables driver.
// - Low-battery code zero turns detection off.
// - Codes 1..9 select 3.0V to 3.8V thresholds.
// - Low-battery threshold resets to code 1.
// - Timer runs only while current exceeds threshold.
// - Timer threshold code zero disables timer entirely.
// - Codes 1..5 select 100 to 300 mA.
// - Timer threshold resets to code 4.
// - Duration limits flash/torch time above threshold.
// - Duration register resets to code 7.
// - Over-range write dropped, register keeps value.
// - Addresses start at one; registers at 3,4,5.
package fscr_pkg;
	localparam logic [2:0] ADDR_TIME_LIMIT    = 3'h3;
	localparam logic [2:0] ADDR_SUPPLY_LIMIT  = 3'h4;
	localparam logic [2:0] ADDR_CURRENT_LIMIT = 3'h5;
	localparam logic [2:0] TIME_LIMIT_MAX     = 3'h7;
	localparam logic [3:0] SUPPLY_LIMIT_MAX   = 4'h9;
	localparam logic [2:0] CURRENT_LIMIT_MAX  = 3'h5;
	localparam logic [2:0] TIME_LIMIT_RST     = 3'h7;
	localparam logic [3:0] SUPPLY_LIMIT_RST   = 4'h1;
	localparam logic [2:0] CURRENT_LIMIT_RST  = 3'h4;
	// Timeout step in microseconds (156.25 ms)
	localparam int unsigned TIME_STEP_US      = 156250;
	localparam int unsigned CLK_MHZ           = 100;
	localparam int unsigned TIME_STEP_CYC     = TIME_STEP_US * CLK_MHZ;
	// Supply threshold in millivolts, base and step
	localparam logic [12:0] SUPPLY_BASE_MV    = 13'hBB8;
	localparam logic [12:0] SUPPLY_STEP_MV    = 13'h064;
	// Current threshold in milliamps, base and step
	localparam logic [10:0] CURRENT_BASE_MA   = 11'h064;
	localparam logic [10:0] CURRENT_STEP_MA   = 11'h032;
endpackage

// *** fscr_top.sv ***
// Safety configuration registers with decoded limits and safety timer.
// Assumes supply (mV) and LED current (mA) words already on this clock.
`timescale 1ns/100ps
module fscr_top #(
	parameter int unsigned STEP_CYC = fscr_pkg::TIME_STEP_CYC
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_clk_en,
	input  wire logic        i_wr_stb,
	input  wire logic [2:0]  i_wr_addr,
	input  wire logic [4:0]  i_wr_data,
	input  wire logic        i_mode_active,
	input  wire logic [12:0] i_supply_mv,
	input  wire logic [10:0] i_led_ma,
	output logic [2:0]       o_safety_time_limit,
	output logic [3:0]       o_supply_low_limit,
	output logic [2:0]       o_timer_current_limit,
	output logic             o_low_batt,
	output logic             o_drive_en,
	output logic             o_timeout,
	output logic             o_wr_reject
);
	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	logic [2:0] time_q;
	logic [3:0] supply_q;
	logic [2:0] curr_q;
	logic       reject_q;
	logic       hit_t;
	logic       hit_s;
	logic       hit_c;
	logic       bad;
	logic       ok_t;
	logic       ok_s;
	logic       ok_c;

	assign hit_t = i_wr_stb && (i_wr_addr == fscr_pkg::ADDR_TIME_LIMIT);
	assign hit_s = i_wr_stb && (i_wr_addr == fscr_pkg::ADDR_SUPPLY_LIMIT);
	assign hit_c = i_wr_stb && (i_wr_addr == fscr_pkg::ADDR_CURRENT_LIMIT);
	assign ok_t = (i_wr_data[4:3] == 2'h0) && (i_wr_data[2:0] <= fscr_pkg::TIME_LIMIT_MAX);
	assign ok_s = (i_wr_data[4] == 1'b0) && (i_wr_data[3:0] <= fscr_pkg::SUPPLY_LIMIT_MAX);
	assign ok_c = (i_wr_data[4:3] == 2'h0) && (i_wr_data[2:0] <= fscr_pkg::CURRENT_LIMIT_MAX);
	assign bad  = (hit_t && !ok_t) || (hit_s && !ok_s) || (hit_c && !ok_c);

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			time_q   <= fscr_pkg::TIME_LIMIT_RST;
			supply_q <= fscr_pkg::SUPPLY_LIMIT_RST;
			curr_q   <= fscr_pkg::CURRENT_LIMIT_RST;
			reject_q <= 1'b0;
		end else if (i_clk_en) begin
			reject_q <= bad;
			if (hit_t && ok_t) begin
				time_q <= i_wr_data[2:0];
			end
			if (hit_s && ok_s) begin
				supply_q <= i_wr_data[3:0];
			end
			if (hit_c && ok_c) begin
				curr_q <= i_wr_data[2:0];
			end
		end
	end

	// ----------------------------------------
	// Decoded limits
	// ----------------------------------------
	logic [12:0] supply_th;
	logic [10:0] curr_th;
	logic [31:0] limit_cyc;

	assign supply_th = 13'(fscr_pkg::SUPPLY_BASE_MV + 13'(fscr_pkg::SUPPLY_STEP_MV * 13'(supply_q - 4'h1)));
	assign curr_th = 11'(fscr_pkg::CURRENT_BASE_MA + 11'(fscr_pkg::CURRENT_STEP_MA * 11'(curr_q - 3'h1)));
	assign limit_cyc = 32'((32'(time_q) + 32'h1) * 32'(STEP_CYC));

	// ----------------------------------------
	// Low battery
	// ----------------------------------------
	logic low_q;
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			low_q <= 1'b0;
		end else if (i_clk_en) begin
			low_q <= (supply_q != 4'h0) && (i_supply_mv < supply_th);
		end
	end

	// ----------------------------------------
	// Safety timer
	// ----------------------------------------
	logic [31:0] cnt_q;
	logic        tout_q;
	logic        drive_q;
	logic        above;
	logic        act_q;

	assign above = (curr_q != 3'h0) && (i_led_ma > curr_th);

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q  <= 32'h0;
			tout_q <= 1'b0;
			act_q  <= 1'b0;
		end else if (i_clk_en) begin
			act_q <= i_mode_active;
			if (!i_mode_active) begin
				cnt_q  <= 32'h0;
				tout_q <= 1'b0;
			end else if (i_mode_active && !act_q) begin
				cnt_q  <= 32'h0;
				tout_q <= 1'b0;
			end else if (!tout_q && above) begin
				if (cnt_q + 32'h1 >= limit_cyc) begin
					tout_q <= 1'b1;
				end
				cnt_q <= 32'(cnt_q + 32'h1);
			end
		end
	end

	// Drive: active mode, no timeout, no low battery
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			drive_q <= 1'b0;
		end else if (i_clk_en) begin
			drive_q <= i_mode_active && !tout_q && !low_q;
		end
	end

	assign o_safety_time_limit   = time_q;
	assign o_supply_low_limit    = supply_q;
	assign o_timer_current_limit = curr_q;
	assign o_low_batt            = low_q;
	assign o_drive_en            = drive_q;
	assign o_timeout             = tout_q;
	assign o_wr_reject           = reject_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_bad_write;
		i_clk_en && bad;
	endsequence

	a_reject_keeps_value: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_bad_write |=> (o_wr_reject && $stable(time_q) && $stable(supply_q) && $stable(curr_q)))
		else $error("invalid write changed a register");
	a_lowbatt_off_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && supply_q == 4'h0) |=> !low_q)
		else $error("low battery flagged while disabled");
	a_lowbatt_kills_drive: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && low_q) |=> !drive_q)
		else $error("drive on during low battery");
	a_timer_off_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && act_q && i_mode_active && curr_q == 3'h0 && !tout_q) |=> $stable(cnt_q))
		else $error("timer ran while disabled");
	a_timer_below_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && act_q && i_mode_active && !above) |=> $stable(cnt_q))
		else $error("timer ran below threshold");
	a_timeout_kills_drive: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && tout_q) |=> !drive_q)
		else $error("drive on after timeout");
	a_supply_decode: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(supply_q == 4'h9) |-> (supply_th == 13'hED8))
		else $error("code 9 not 3.8V");
	a_current_decode: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(curr_q == 3'h5) |-> (curr_th == 11'h12C))
		else $error("code 5 not 300 mA");
	a_timeout_bound: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		tout_q |-> (cnt_q == limit_cyc))
		else $error("timeout at wrong count");

	// ----------------------------------------
	// Write, freeze, low-battery and timer checks
	// ----------------------------------------
	// Accepted writes, one per register
	sequence s_good_time_write;
		i_clk_en && hit_t && ok_t;
	endsequence
	sequence s_good_supply_write;
		i_clk_en && hit_s && ok_s;
	endsequence
	sequence s_good_curr_write;
		i_clk_en && hit_c && ok_c;
	endsequence
	// Host re-enable and one counted cycle
	sequence s_mode_rise;
		i_clk_en && i_mode_active && !act_q;
	endsequence
	sequence s_count_step;
		i_clk_en && act_q && i_mode_active && !tout_q && above;
	endsequence

	a_time_write_lands: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_good_time_write |=> (time_q == 3'($past(i_wr_data))))
		else $error("duration write lost");

	a_supply_write_lands: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_good_supply_write |=> (supply_q == 4'($past(i_wr_data))))
		else $error("supply limit write lost");

	a_curr_write_lands: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_good_curr_write |=> (curr_q == 3'($past(i_wr_data))))
		else $error("current limit write lost");

	a_unmapped_ignored: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && i_wr_stb && !hit_t && !hit_s && !hit_c)
		|=> (!reject_q && $stable(time_q) && $stable(supply_q) && $stable(curr_q)))
		else $error("unmapped write had an effect");

	a_good_no_reject: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && !bad) |=> !reject_q)
		else $error("reject without invalid write");

	// Clock enable low freezes registers
	a_freeze_regs: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		!i_clk_en |=> ($stable(time_q) && $stable(supply_q) && $stable(curr_q) && $stable(cnt_q)))
		else $error("register moved while frozen");

	// Clock enable low freezes flags
	a_freeze_flags: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		!i_clk_en |=> ($stable(low_q) && $stable(drive_q) && $stable(reject_q) && $stable(tout_q)))
		else $error("flag moved while frozen");

	a_lowbatt_sets: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && supply_q != 4'h0 && i_supply_mv < supply_th) |=> low_q)
		else $error("low supply not flagged");

	a_lowbatt_clears: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && !(i_supply_mv < supply_th)) |=> !low_q)
		else $error("low battery flagged at good supply");

	a_mode_rise_clears: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_mode_rise |=> (!tout_q && cnt_q == 32'h0))
		else $error("re-enable did not restart timer");

	a_mode_low_clears: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && !i_mode_active) |=> (!tout_q && !drive_q && cnt_q == 32'h0))
		else $error("mode off left timer or drive");

	a_count_steps: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_count_step |=> (cnt_q == 32'($past(cnt_q) + 32'h1)))
		else $error("timer did not advance");

	a_timeout_sticky: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && tout_q && act_q && i_mode_active) |=> tout_q)
		else $error("timeout dropped while active");

	a_timeout_reached: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(s_count_step ##0 (32'(cnt_q + 32'h1) >= limit_cyc)) |=> tout_q)
		else $error("timeout missed at limit");

	a_timer_off_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(i_clk_en && curr_q == 3'h0 && !tout_q) |=> !tout_q)
		else $error("timeout while timer disabled");

	// ----------------------------------------
	// Decode checks, one per duration code and per nonzero threshold code
	// ----------------------------------------
	for (genvar k = 0; k <= 7; k++) begin : g_time_chk
		localparam int unsigned LIMIT = (k + 1) * STEP_CYC;
		a_time_each: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
			(time_q == 3'(k)) |-> (limit_cyc == 32'(LIMIT)))
			else $error("duration decode wrong");
	end

	for (genvar k = 1; k <= 9; k++) begin : g_supply_chk
		localparam int MV = int'(fscr_pkg::SUPPLY_BASE_MV) + int'(fscr_pkg::SUPPLY_STEP_MV) * (k - 1);
		a_supply_each: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
			(supply_q == 4'(k)) |-> (int'(supply_th) == MV))
			else $error("supply threshold decode wrong");
	end

	for (genvar k = 1; k <= 5; k++) begin : g_curr_chk
		localparam int MA = int'(fscr_pkg::CURRENT_BASE_MA) + int'(fscr_pkg::CURRENT_STEP_MA) * (k - 1);
		a_curr_each: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
			(curr_q == 3'(k)) |-> (int'(curr_th) == MA))
			else $error("current threshold decode wrong");
	end
endmodule // fscr_top

// *** fscr_host.sv ***
// Host model: issues decoded register writes as one-cycle strobes.
// Assumes one caller at a time, on the device clock.
`timescale 1ns/100ps
module fscr_host (
	input  wire logic       i_sys_clk,
	output logic            o_wr_stb,
	output logic [2:0]      o_wr_addr,
	output logic [4:0]      o_wr_data
);
	// ----------------
	// Write cycle
	// ----------------
	// mapped addressing
	task automatic write(input logic [2:0] a, input logic [4:0] d);
		@(posedge i_sys_clk);
		o_wr_stb  <= 1'h1;
		o_wr_addr <= a;
		o_wr_data <= d;
		@(posedge i_sys_clk);
		o_wr_stb  <= 1'h0;
		// Released data lines never keep old data; the address lines keep the last address
		o_wr_data <= ~d;
	endtask
	initial begin
		o_wr_stb  = 1'h0;
		o_wr_addr = 3'h0;
		o_wr_data = 5'h0;
	end
endmodule // fscr_host

// *** fscr_top_tb.sv ***
// Self-checking bench for the safety configuration registers.
// Assumes a short timer step so every time-out ends quickly.
`timescale 1ns/100ps
module fscr_top_tb;
	// ----------------
	// Bench
	// ----------------
	localparam int STEP = 10;
	logic        i_sys_clk = 1'h0;
	logic        i_rst_n   = 1'h0;
	logic        mode      = 1'h0;
	logic        ce        = 1'h1;
	logic [12:0] mv        = 13'hFA0;
	logic [10:0] ma        = 11'h0;
	logic [2:0]  tl        = 3'h7;
	logic [3:0]  sl        = 4'h1;
	logic [2:0]  cl        = 3'h4;
	logic        stb;
	logic [2:0]  addr;
	logic [4:0]  data;
	wire  [13:0] seen;
	logic [13:0] q[$];
	int          err_count = 0;
	int          checked   = 0;
	event        smp;
	always #5 i_sys_clk = ~i_sys_clk;
	fscr_host HOST (.i_sys_clk(i_sys_clk), .o_wr_stb(stb), .o_wr_addr(addr), .o_wr_data(data));
	fscr_top #(.STEP_CYC(STEP)) DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(ce),
		.i_wr_stb(stb), .i_wr_addr(addr), .i_wr_data(data), .i_mode_active(mode), .i_supply_mv(mv),
		.i_led_ma(ma), .o_safety_time_limit(seen[13:11]), .o_supply_low_limit(seen[10:7]),
		.o_timer_current_limit(seen[6:4]), .o_low_batt(seen[3]), .o_drive_en(seen[2]),
		.o_timeout(seen[1]), .o_wr_reject(seen[0]));
	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask
	// Flags are {low_batt, drive_en, timeout, reject}
	task automatic note(input logic [3:0] f);
		q.push_back({tl, sl, cl, f});
		->smp;
	endtask
	task automatic compare(input logic [13:0] e, input logic [13:0] s);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("unexpected outputs expected %h seen %h", e, s);
		end
	endtask
	// Sample once the edge's updates have landed
	always @(smp) begin
		#1;
		compare(q.pop_front(), seen);
	end
	task automatic finish_test;
		if (err_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		cyc(5000);
		err_count++;
		finish_test();
	end
	initial begin
		void'($urandom(4));
		cyc(20);
		i_rst_n <= 1'h1;
		cyc(2);
		note(4'h0);
		for (int k = 0; k < 4; k++) begin
			tl = 3'($urandom % 8);
			HOST.write(3'h3, {2'h0, tl});
			note(4'h0);
			sl = 4'(1 + $urandom % 9);
			HOST.write(3'h4, {1'h0, sl});
			note(4'h0);
			cl = 3'(1 + $urandom % 5);
			HOST.write(3'h5, {2'h0, cl});
			note(4'h0);
		end
		HOST.write(3'h3, 5'(8 + $urandom % 24));
		note(4'h1);
		HOST.write(3'h4, 5'(10 + $urandom % 22));
		note(4'h1);
		HOST.write(3'h5, 5'h6);
		note(4'h1);
		HOST.write(3'h6, 5'h1);
		note(4'h0);
		ce <= 1'h0;
		HOST.write(3'h3, {2'h0, ~tl});
		ce <= 1'h1;
		note(4'h0);
		mode <= 1'h1;
		for (int n = 0; n < 10; n++) begin
			sl = 4'(n);
			HOST.write(3'h4, {1'h0, sl});
			mv <= 13'(2899 + 100 * n);
			cyc(3);
			note({n != 0, n == 0, 2'h0});
			mv <= 13'(2900 + 100 * n);
			cyc(3);
			note(4'h4);
		end
		cl = 3'h1;
		HOST.write(3'h5, 5'h1);
		ma <= 11'h64;
		cyc(40);
		note(4'h4);
		ma <= 11'h65;
		for (int t = 0; t < 8; t++) begin
			tl = 3'(t);
			mode <= 1'h0;
			HOST.write(3'h3, {2'h0, tl});
			mode <= 1'h1;
			cyc(STEP * (t + 1));
			note(4'h4);
			cyc(1);
			note(4'h6);
			cyc(1);
			note(4'h2);
		end
		cl = 3'h0;
		HOST.write(3'h5, 5'h0);
		ma <= 11'h12C;
		mode <= 1'h0;
		cyc(2);
		mode <= 1'h1;
		cyc(100);
		note(4'h4);
		cyc(2);
		finish_test();
	end
endmodule // fscr_top_tb
